/* design/in_system_flash_update_control.sv */
// Register file, unlock, update mode and bank switching for flash update.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - The programming control register is read-only until 87H then 59H are written to the unlock register.
// - Any other value written to the unlock register closes control writes.
// - With control bit 0 set, update mode begins at the next wake from idle.
// - Flash operations run while the processor idles and end before wake.
// - On wake into update mode, fetching moves to the loader bank.
// - The bank switch clears the program counter so execution starts at 00H.
// - Writing ones to control bits 0, 1 and 7 issues a software reset.
// - The software reset acts as an external reset and returns to the application bank.
// - Normal execution is from the application bank; the loader bank is separate.
// - The target address is the high byte register above the low byte register.
// - The data byte register gives the byte to program and takes read results.
// - Command bit 6 picks the destination bank, one for the loader bank.
// - Command bits 5, 4 and 3..0 drive output enable, chip enable and control lines.
// - A command of all zeros reads the target byte into the data register.
module in_system_flash_update_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [isu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor core
  input wire logic cpuIdle,
  output logic wakeHold,
  output logic execLoaderBank,
  output logic pcClear,
  output logic cpuSwReset,
  // Flash array
  output logic [15:0] flashAddr,
  output logic [7:0] flashWrData,
  output logic flashDataOe,
  output logic flashBankSel,
  output logic flashOe,
  output logic flashCe,
  output logic [3:0] flashCtrl,
  input wire logic [7:0] flashRdData
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic regHit(input logic [isu_pkg::ADDR_W-1:0] a,
                                  input logic [7:0] idx);
    regHit = (a == {2'b00, idx, 2'b00});
  endfunction

  flash_op_if op ();

  logic [7:0] cmd_r;
  logic [7:0] addrHi_r;
  logic [7:0] addrLo_r;
  logic [7:0] data_r;
  logic [7:0] ctrl_r;
  logic keyStep_r;
  logic wrOpen_r;
  logic updateMode_r;
  logic idlePrev_r;
  logic opRead_r;
  logic start_r;
  logic [7:0] wrByte;
  logic accessCycle;
  logic wrCycle;
  logic hitCmd;
  logic hitAddrHi;
  logic hitAddrLo;
  logic hitData;
  logic hitCtrl;
  logic hitUnlock;
  logic hitStatus;
  logic mapped;
  logic [7:0] statusByte;
  logic [7:0] rdByte;
  logic ctrlWrite;
  logic swResetReq;
  logic rstAll;
  logic idleRise;
  logic idleFall;
  logic opLaunch;
  logic enterUpdate;
  logic readDone;
  logic [31:0] rdWord;
  logic holdNxt;
  logic unlockWr;
  logic keyFirst;
  logic keySecond;
  logic updateReq;

  ////////////////////////////////////////////////////////////////////////////

  // A software reset clears this block as the reset pin does, except pready, prdata, pslverr and cpuSwReset.
  assign rstAll = rst | cpuSwReset;

  assign wrByte = pwdata[7:0];
  assign accessCycle = psel & penable & ~pready;
  assign wrCycle = psel & penable & pready & pwrite;

  assign hitCmd = regHit(paddr, isu_pkg::IDX_CMD);
  assign hitAddrHi = regHit(paddr, isu_pkg::IDX_ADDR_HI);
  assign hitAddrLo = regHit(paddr, isu_pkg::IDX_ADDR_LO);
  assign hitData = regHit(paddr, isu_pkg::IDX_DATA);
  assign hitCtrl = regHit(paddr, isu_pkg::IDX_CTRL);
  assign hitUnlock = regHit(paddr, isu_pkg::IDX_UNLOCK);
  assign hitStatus = regHit(paddr, isu_pkg::IDX_STATUS);
  assign mapped = hitCmd | hitAddrHi | hitAddrLo | hitData | hitCtrl |
    hitUnlock | hitStatus;

  assign statusByte = {4'h0,
    execLoaderBank,
    op.busy,
    wrOpen_r,
    updateMode_r};

  assign rdByte = hitCmd ? (cmd_r & isu_pkg::CMD_MASK) :
    hitAddrHi ? addrHi_r :
    hitAddrLo ? addrLo_r :
    hitData ? data_r :
    hitCtrl ? ctrl_r :
    hitStatus ? statusByte :
    isu_pkg::RST_BYTE;

  // Closed control register drops the write silently.
  assign ctrlWrite = wrCycle & hitCtrl & wrOpen_r;
  assign swResetReq = ctrlWrite &
    ((wrByte & isu_pkg::CTRL_SWRST_MASK) ==
     isu_pkg::CTRL_SWRST_MASK);

  assign rdWord = {24'h000000, pwrite ? isu_pkg::RST_BYTE : rdByte};

  ////////////////////////////////////////////////////////////////////////////

  // APB answer: one wait state, then pready with data or error.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= accessCycle;
      if (accessCycle) begin
        prdata <= rdWord;
        pslverr <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Unlock sequence.
  assign unlockWr = wrCycle & hitUnlock;
  assign keyFirst = (wrByte == isu_pkg::UNLOCK_KEY1);
  assign keySecond = (wrByte == isu_pkg::UNLOCK_KEY2);

  always_ff @(posedge clk) begin
    if (rstAll) begin
      keyStep_r <= 1'b0;
      wrOpen_r <= 1'b0;
    end else if (unlockWr) begin
      if (keyFirst) begin
        keyStep_r <= 1'b1;
      end else if (keySecond) begin
        keyStep_r <= 1'b0;
        if (keyStep_r) begin
          wrOpen_r <= 1'b1;
        end
      end else begin
        keyStep_r <= 1'b0;
        wrOpen_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Software registers.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      ctrl_r <= isu_pkg::RST_BYTE;
      cmd_r <= isu_pkg::RST_BYTE;
      addrHi_r <= isu_pkg::RST_BYTE;
      addrLo_r <= isu_pkg::RST_BYTE;
    end else if (wrCycle) begin
      if (ctrlWrite) begin
        ctrl_r <= wrByte;
      end
      if (hitCmd) begin
        cmd_r <= wrByte & isu_pkg::CMD_MASK;
      end
      if (hitAddrHi) begin
        addrHi_r <= wrByte;
      end
      if (hitAddrLo) begin
        addrLo_r <= wrByte;
      end
    end
  end

  // A finished read wins over a software write in the same cycle.
  assign readDone = op.done & opRead_r;

  always_ff @(posedge clk) begin
    if (rstAll) begin
      data_r <= isu_pkg::RST_BYTE;
    end else if (readDone) begin
      data_r <= op.rdData;
    end else if (wrCycle & hitData) begin
      data_r <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Idle entry launches the flash access; wake carries the mode change.
  assign idleRise = cpuIdle & ~idlePrev_r;
  assign idleFall = ~cpuIdle & idlePrev_r;
  assign updateReq = ctrl_r[isu_pkg::CTRL_UPDATE_BIT];
  assign opLaunch = idleRise & ~op.busy &
    (updateMode_r | updateReq);
  assign enterUpdate = idleFall & ~updateMode_r &
    updateReq;

  always_ff @(posedge clk) begin
    if (rstAll) begin
      idlePrev_r <= 1'b0;
      start_r <= 1'b0;
      opRead_r <= 1'b0;
    end else begin
      idlePrev_r <= cpuIdle;
      start_r <= opLaunch;
      if (opLaunch) begin
        opRead_r <= (cmd_r == isu_pkg::CMD_READ);
      end
    end
  end

  assign op.start = start_r;
  assign op.cmd = cmd_r;
  assign op.addr = {addrHi_r, addrLo_r};
  assign op.wrData = data_r;

  // Wake waits until the access ends, which the engine's cycle timer decides.
  assign holdNxt = opLaunch | start_r | (op.busy & ~op.done);

  ////////////////////////////////////////////////////////////////////////////

  // Core-facing controls. The loader bank is left only through a reset,
  // so a failed update cannot drop back into a half-written application.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      updateMode_r <= 1'b0;
      execLoaderBank <= 1'b0;
      pcClear <= 1'b0;
      wakeHold <= 1'b0;
    end else begin
      pcClear <= enterUpdate;
      wakeHold <= holdNxt;
      if (enterUpdate) begin
        updateMode_r <= 1'b1;
        execLoaderBank <= 1'b1;
      end
    end
  end

  // The reset pulse lasts one cycle; its register is reset by the pin reset only, not by rstAll.
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuSwReset <= 1'b0;
    end else begin
      cpuSwReset <= swResetReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  flash_op_engine engine (
    .clk(clk),
    .rst(rstAll),
    .op(op.engine),
    .flashAddr(flashAddr),
    .flashWrData(flashWrData),
    .flashDataOe(flashDataOe),
    .flashBankSel(flashBankSel),
    .flashOe(flashOe),
    .flashCe(flashCe),
    .flashCtrl(flashCtrl),
    .flashRdData(flashRdData)
  );

endmodule

/* design/isu_pkg.sv */
// Constants and types shared by the flash update control design.
package isu_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CMD = 8'hC7;
  localparam logic [7:0] IDX_ADDR_LO = 8'hC4;
  localparam logic [7:0] IDX_ADDR_HI = 8'hC5;
  localparam logic [7:0] IDX_DATA = 8'hC6;
  localparam logic [7:0] IDX_CTRL = 8'hBF;
  localparam logic [7:0] IDX_UNLOCK = 8'hF6;
  localparam logic [7:0] IDX_STATUS = 8'hF7;
  localparam int ADDR_W = 12;
  // Unlock sequence codes.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h87;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h59;
  // Programming control fields.
  localparam int CTRL_UPDATE_BIT = 0;
  localparam logic [7:0] CTRL_SWRST_MASK = 8'h83;
  // Flash command fields; bit 7 is reserved and reads zero.
  localparam int CMD_BANK_BIT = 6;
  localparam int CMD_OE_BIT = 5;
  localparam int CMD_CE_BIT = 4;
  localparam int CMD_LINES_W = 4;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_MASK = 8'h7F;
  // Control-line encodings for program and erase; arbitrary defaults.
  localparam logic [3:0] LINES_PROGRAM = 4'h1;
  localparam logic [3:0] LINES_ERASE = 4'h2;
  // Status register bits.
  localparam int STAT_UPDATE_BIT = 0;
  localparam int STAT_WREN_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_LOADER_BIT = 3;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  // Flash access strobe time and its cycle count at 20 MHz.
  localparam int FLASH_ACCESS_NS = 200;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACCESS_CYCLES =
    (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  typedef enum logic {OP_IDLE, OP_DRIVE} opState_e;
endpackage

/* design/flash_op_if.sv */
// Request and answer signals between the control logic and the flash engine.
`timescale 1ns/1ps
interface flash_op_if;
  logic start;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [7:0] wrData;
  logic done;
  logic busy;
  logic [7:0] rdData;
  modport ctrl (output start, output cmd, output addr, output wrData,
    input done, input busy, input rdData);
  modport engine (input start, input cmd, input addr, input wrData,
    output done, output busy, output rdData);
endinterface

/* design/flash_op_engine.sv */
// Drives one flash access from a latched command and returns read data.
`timescale 1ns/1ps
module flash_op_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  flash_op_if.engine op,
  // Flash array side
  output logic [15:0] flashAddr,
  output logic [7:0] flashWrData,
  output logic flashDataOe,
  output logic flashBankSel,
  output logic flashOe,
  output logic flashCe,
  output logic [3:0] flashCtrl,
  input wire logic [7:0] flashRdData
);
  isu_pkg::opState_e state_r;
  logic [isu_pkg::CNT_W-1:0] cnt_r;
  logic lastCycle;
  logic isProgram;

  assign lastCycle = (state_r == isu_pkg::OP_DRIVE) && (cnt_r == '0);
  assign isProgram = op.cmd[isu_pkg::CMD_LINES_W-1:0] ==
    isu_pkg::LINES_PROGRAM;
  assign op.busy = (state_r != isu_pkg::OP_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= isu_pkg::OP_IDLE;
      cnt_r <= '0;
      op.done <= 1'b0;
      op.rdData <= isu_pkg::RST_BYTE;
      flashAddr <= isu_pkg::RST_ADDR;
      flashWrData <= isu_pkg::RST_BYTE;
      flashDataOe <= 1'b0;
      flashBankSel <= 1'b0;
      flashOe <= 1'b0;
      flashCe <= 1'b0;
      flashCtrl <= '0;
    end else begin
      op.done <= lastCycle;
      case (state_r)
        isu_pkg::OP_IDLE: begin
          if (op.start) begin
            state_r <= isu_pkg::OP_DRIVE;
            cnt_r <= isu_pkg::CNT_W'(isu_pkg::ACCESS_CYCLES - 1);
            flashAddr <= op.addr;
            flashWrData <= op.wrData;
            flashDataOe <= isProgram;
            flashBankSel <= op.cmd[isu_pkg::CMD_BANK_BIT];
            flashOe <= op.cmd[isu_pkg::CMD_OE_BIT];
            flashCe <= op.cmd[isu_pkg::CMD_CE_BIT];
            flashCtrl <= op.cmd[isu_pkg::CMD_LINES_W-1:0];
          end
        end
        isu_pkg::OP_DRIVE: begin
          cnt_r <= cnt_r - 1'b1;
          if (lastCycle) begin
            // The array is sampled before the lines are released.
            op.rdData <= flashRdData;
            state_r <= isu_pkg::OP_IDLE;
            flashDataOe <= 1'b0;
            flashOe <= 1'b0;
            flashCe <= 1'b0;
            flashCtrl <= '0;
          end
        end
        default: state_r <= isu_pkg::OP_IDLE;
      endcase
    end
  end
endmodule

/* tb/isu_checker.sv */
// Port assertions for the flash update control block.
`timescale 1ns/1ps
module isu_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic pready,
  input wire logic pwrite,
  input wire logic [isu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  // Core and flash
  input wire logic cpuIdle,
  input wire logic wakeHold,
  input wire logic execLoaderBank,
  input wire logic pcClear,
  input wire logic cpuSwReset,
  input wire logic [15:0] flashAddr,
  input wire logic flashBankSel,
  input wire logic flashOe,
  input wire logic flashCe,
  input wire logic [3:0] flashCtrl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire cmdRead = pready && !pwrite &&
    paddr == {2'b00, isu_pkg::IDX_CMD, 2'b00};
  ////////////////////////////////////////////////////////////
  a_hold_cause: assert property ($rose(wakeHold) |->
    $past(cpuIdle) && !$past(cpuIdle, 2))
    else $error("Access began without idle entry.");
  a_hold_span: assert property ($rose(wakeHold) |->
    wakeHold [*6] ##1 !wakeHold)
    else $error("Wake hold has the wrong length.");
  a_lines_quiet: assert property (!wakeHold |->
    !flashCe && !flashOe && flashCtrl == 4'h0)
    else $error("Flash lines driven outside an access.");
  a_addr_held: assert property (flashCe && $past(flashCe) |->
    $stable(flashAddr) && $stable(flashBankSel))
    else $error("Target moved during an access.");
  a_pc_clear: assert property ($rose(execLoaderBank) |-> pcClear)
    else $error("Bank switch without counter clear.");
  a_loader_kept: assert property (
    execLoaderBank && !cpuSwReset |=> execLoaderBank)
    else $error("Loader bank left without reset.");
  a_swrst_back: assert property (cpuSwReset |=>
    !cpuSwReset && !execLoaderBank && !wakeHold)
    else $error("Software reset did not restore state.");
  a_rsv_bit: assert property (cmdRead |-> prdata[31:7] == 25'h0)
    else $error("Reserved command bit reads one.");
  cover property (pcClear);
  cover property (cpuSwReset);
  cover property ($fell(wakeHold));
endmodule

/* tb/flash_array_model.sv */
// Behavioural model of the program flash array.
`timescale 1ns/1ps
module flash_array_model #(
  parameter int DLY = 1
) (
  // Clock
  input wire logic clk,
  // Flash lines
  input wire logic [15:0] flashAddr,
  input wire logic flashBankSel,
  input wire logic flashOe,
  input wire logic flashCe,
  output logic [7:0] flashRdData
);
  logic [15:0] prevAddr = 16'h0000;
  logic [7:0] lastVal = 8'h00;
  int age = 0;
  // Enables are low active, so a command of zeros reads.
  wire rdOn = !flashCe && !flashOe;
  always @(posedge clk) begin
    prevAddr <= flashAddr;
    age <= (flashAddr == prevAddr) ? age + 1 : 0;
    lastVal <= flashRdData;
  end
  // Data toggles until the address has settled, so a slow array shows.
  wire settled = (flashAddr == prevAddr) && (age >= DLY);
  assign flashRdData = (rdOn && settled) ?
    flashAddr[7:0] ^ flashAddr[15:8] ^ {flashBankSel, 7'h5A} : ~lastVal;
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the flash update control block.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic cpuIdle = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, wakeHold, execLoaderBank, pcClear, cpuSwReset;
  logic [15:0] flashAddr;
  logic [7:0] flashWrData, flashRdData;
  logic flashDataOe, flashBankSel, flashOe, flashCe, err;
  logic [3:0] flashCtrl;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  in_system_flash_update_control uut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuIdle(cpuIdle), .wakeHold(wakeHold), .execLoaderBank(execLoaderBank),
    .pcClear(pcClear), .cpuSwReset(cpuSwReset), .flashAddr(flashAddr),
    .flashWrData(flashWrData), .flashDataOe(flashDataOe),
    .flashBankSel(flashBankSel), .flashOe(flashOe), .flashCe(flashCe),
    .flashCtrl(flashCtrl), .flashRdData(flashRdData));
  flash_array_model #(.DLY(2)) farSide (.clk(clk), .flashAddr(flashAddr),
    .flashBankSel(flashBankSel), .flashOe(flashOe), .flashCe(flashCe),
    .flashRdData(flashRdData));
  initial begin
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [31:0] exp);
    xfer(1'b0, i, 8'h00);
    chk(rd, exp);
  endtask
  task automatic unlock;
    xfer(1'b1, isu_pkg::IDX_UNLOCK, isu_pkg::UNLOCK_KEY1);
    xfer(1'b1, isu_pkg::IDX_UNLOCK, isu_pkg::UNLOCK_KEY2);
  endtask
  task automatic idleRun;
    @(posedge clk);
    cpuIdle <= 1'b1;
    for (n = 0; n < 20 && flashCe !== 1'b1 && wakeHold !== 1'b1; n++)
      @(posedge clk);
    chk({31'h0, wakeHold}, 32'h1);
  endtask
  task automatic wakeUp;
    for (n = 0; n < 20 && wakeHold !== 1'b0; n++) @(posedge clk);
    cpuIdle <= 1'b0;
  endtask
  task automatic t_lock;
    rdchk(isu_pkg::IDX_CTRL, 32'h0);
    xfer(1'b1, isu_pkg::IDX_CTRL, 8'h40);
    rdchk(isu_pkg::IDX_CTRL, 32'h0);
    xfer(1'b1, isu_pkg::IDX_UNLOCK, isu_pkg::UNLOCK_KEY2);
    xfer(1'b1, isu_pkg::IDX_CTRL, 8'h40);
    rdchk(isu_pkg::IDX_CTRL, 32'h0);
    unlock();
    xfer(1'b1, isu_pkg::IDX_CTRL, 8'h40);
    rdchk(isu_pkg::IDX_CTRL, 32'h40);
    xfer(1'b1, isu_pkg::IDX_UNLOCK, 8'h12);
    xfer(1'b1, isu_pkg::IDX_CTRL, 8'h00);
    rdchk(isu_pkg::IDX_CTRL, 32'h40);
    $display("lock test done");
  endtask
  task automatic t_regs;
    xfer(1'b1, isu_pkg::IDX_ADDR_HI, 8'h12);
    xfer(1'b1, isu_pkg::IDX_ADDR_LO, 8'h34);
    xfer(1'b1, isu_pkg::IDX_DATA, 8'hA5);
    xfer(1'b1, isu_pkg::IDX_CMD, 8'hFF);
    rdchk(isu_pkg::IDX_CMD, 32'h7F);
    rdchk(isu_pkg::IDX_ADDR_HI, 32'h12);
    rdchk(isu_pkg::IDX_DATA, 32'hA5);
    xfer(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("register test done");
  endtask
  task automatic t_read;
    xfer(1'b1, isu_pkg::IDX_CMD, isu_pkg::CMD_READ);
    unlock();
    xfer(1'b1, isu_pkg::IDX_CTRL, 8'h03);
    repeat (2) @(posedge clk);
    chk({31'h0, cpuSwReset}, 32'h0);
    idleRun();
    wakeUp();
    chk({16'h0, flashAddr}, 32'h1234);
    for (n = 0; n < 20 && pcClear !== 1'b1; n++) @(posedge clk);
    chk({31'h0, pcClear}, 32'h1);
    chk({31'h0, execLoaderBank}, 32'h1);
    rdchk(isu_pkg::IDX_STATUS, 32'h0B);
    rdchk(isu_pkg::IDX_DATA, 32'h34 ^ 32'h12 ^ 32'h5A);
    $display("update read test done");
  endtask
  task automatic t_cmd;
    xfer(1'b1, isu_pkg::IDX_CMD, 8'h75);
    idleRun();
    for (n = 0; n < 20 && flashCe !== 1'b1; n++) @(posedge clk);
    chk({flashBankSel, flashOe, flashCe, flashCtrl}, 32'h75);
    wakeUp();
    $display("command line test done");
  endtask
  task automatic t_prog;
    xfer(1'b1, isu_pkg::IDX_DATA, 8'hC3);
    xfer(1'b1, isu_pkg::IDX_CMD, {4'h1, isu_pkg::LINES_PROGRAM});
    idleRun();
    for (n = 0; n < 20 && flashCe !== 1'b1; n++) @(posedge clk);
    chk({23'h0, flashDataOe, flashWrData}, 32'h1C3);
    chk({28'h0, flashCtrl}, {28'h0, isu_pkg::LINES_PROGRAM});
    wakeUp();
    chk({31'h0, flashDataOe}, 32'h0);
    $display("program line test done");
  endtask
  task automatic t_swrst;
    unlock();
    xfer(1'b1, isu_pkg::IDX_CTRL, isu_pkg::CTRL_SWRST_MASK);
    for (n = 0; n < 20 && cpuSwReset !== 1'b1; n++) @(posedge clk);
    chk({31'h0, cpuSwReset}, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, execLoaderBank}, 32'h0);
    rdchk(isu_pkg::IDX_ADDR_HI, 32'h0);
    rdchk(isu_pkg::IDX_CTRL, 32'h0);
    $display("software reset test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, execLoaderBank}, 32'h0);
    t_lock();
    t_regs();
    t_read();
    t_cmd();
    t_prog();
    t_swrst();
    conclude();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
bind in_system_flash_update_control isu_checker portCheck (.clk(clk),
  .rst(rst), .pready(pready), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .cpuIdle(cpuIdle), .wakeHold(wakeHold),
  .execLoaderBank(execLoaderBank), .pcClear(pcClear),
  .cpuSwReset(cpuSwReset), .flashAddr(flashAddr),
  .flashBankSel(flashBankSel), .flashOe(flashOe), .flashCe(flashCe),
  .flashCtrl(flashCtrl));
